// [hdl/dlpct_cfg.svh]
`ifndef DLPCT_CFG_SVH
`define DLPCT_CFG_SVH
// Overview of operation
// - Wait 1024 cycles after initial calibration
// - Wait 512 cycles after long calibration
// - Wait 128 cycles after short calibration
// - Reset exit: max(5 cycles, refresh+10ns)
// - Self-refresh exit: refresh time plus 10ns
// - Abort mode: 4x refresh time plus 10ns
// - Calibration, timing writes wait 4x refresh+10ns
// - Locked-loop commands wait lock time
// - Clock enable low: pulse width+1, +parity in self refresh; pulse width alone in power-down
// - Clock held max(5,10ns) after entry, +parity
// - Clock valid max(5,10ns) before exit
// - Clock held update plus disable delay
// - Clock valid before saving-mode exit
// - Saving exit: unlocked commands wait exit delay
// - Saving exit: locked commands add lock delay
// - Select set up before clock enable
// - Low select held 12ns, below exit-10ns
// - Power-down exit delay max(4, 6ns)

// ----------------------------------------
// Clock and rounding
// ----------------------------------------
`define DLPCT_CLK_NS 10
`define DLPCT_CYC(ns) (((ns) + `DLPCT_CLK_NS - 1) / `DLPCT_CLK_NS)
`define DLPCT_MAX(a, b) (((a) > (b)) ? (a) : (b))

// ----------------------------------------
// Interval figures
// ----------------------------------------
`define DLPCT_INIT_CAL_CYC 1024
`define DLPCT_FULL_CAL_CYC 512
`define DLPCT_SHORT_CAL_CYC 128
`define DLPCT_MIN_NCK 5
`define DLPCT_PAD_NS 10
`define DLPCT_CPDED_CYC 4
`define DLPCT_XP_NCK 4
`define DLPCT_XP_NS 6
`define DLPCT_CKE_NCK 3
`define DLPCT_CKE_NS 5
`define DLPCT_CKESR_EXTRA 1
`define DLPCT_LOW_HOLD_NS 12
`define DLPCT_ONE_CYC 1
`endif

// [hdl/dlpct_pkg.sv]
package dlpct_pkg;
  typedef enum logic [3:0] {
    OP_LONG_CAL, OP_SHORT_CAL, OP_MODE_TIMING, OP_CMD_NODLL, OP_CMD_DLL,
    OP_SR_ENTER, OP_PD_ENTER, OP_LP_EXIT, OP_MP_ENTER, OP_MP_EXIT
  } dlpct_op_type;

  typedef enum logic [2:0] {
    CMD_DESELECT, CMD_LONG_CAL, CMD_SHORT_CAL, CMD_MODE_WRITE,
    CMD_SELFREF_ENTRY, CMD_SELFREF_EXIT, CMD_USER
  } dlpct_cmd_type;

  typedef enum logic [3:0] {
    ST_BOOT, ST_RST, ST_RST_CLK, ST_XPR, ST_IDLE, ST_LP_HOLD, ST_LP_IN,
    ST_LP_PRECLK, ST_MP_HOLD, ST_MP_IN, ST_MP_PRECLK, ST_MP_SETUP, ST_MP_LOWHOLD
  } dlpct_state_type;
endpackage : dlpct_pkg

// [hdl/dlpct_tmr_if.sv]
`timescale 1ns/1ps
interface dlpct_tmr_if #(parameter int W = 16) (
  input wire logic clk,
  input wire logic rst
);
  logic         load;
  logic [W-1:0] value;
  logic         done;
  modport ctrl (output load, output value, input done);
  modport tmr  (input clk, input rst, input load, input value, output done);
endinterface : dlpct_tmr_if

// [hdl/dlpct_timer.sv]
`timescale 1ns/1ps
module dlpct_timer #(
  parameter int W = 16
) (
  dlpct_tmr_if.tmr bus
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // Done is a plain decode of the count; gating it with load would close a
  // zero-delay loop through the request handshake of the sequencer
  assign count_next = bus.load ? bus.value :
                      (count_reg != '0) ? count_reg - W'(1) : count_reg;
  assign bus.done   = (count_reg == '0);

  always_ff @(posedge bus.clk or posedge bus.rst) begin
    if (bus.rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : dlpct_timer

// [hdl/dlpct_ctrl.sv]
`timescale 1ns/1ps
`include "dlpct_cfg.svh"
module dlpct_ctrl
  import dlpct_pkg::*;
#(
  parameter int TW             = 16,
  parameter int TRFC_NS        = 350,
  parameter int REFRESH_CYCLE_TIME_4X_NS       = 160,
  parameter int LOCKED_LOOP_LOCK_TIME_CYC      = 768,
  parameter int MODE_UPDATE_DELAY_CYC       = 24,
  parameter int TISH_NS        = 1,
  parameter int RESET_HOLD_CYC = 20
) (
  input  wire logic          sys_clk_i,
  input  wire logic          reset_i,
  input  wire logic          req_valid_i,
  input  wire dlpct_op_type  req_op_i,
  output logic               req_ready_o,
  input  wire logic          abort_en_i,
  input  wire logic          parity_en_i,
  input  wire logic [3:0]    parity_latency_i,
  output dlpct_cmd_type      cmd_o,
  output logic               cs_n_o,
  output logic               cke_o,
  output logic               reset_n_o,
  output logic               ck_en_o,
  output logic               init_done_o,
  output logic               in_selfref_o,
  output logic               in_powerdown_o,
  output logic               in_saving_o,
  output logic               nodll_ok_o,
  output logic               dll_ok_o
);
  // ----------------------------------------
  // Interval lengths in cycles
  // ----------------------------------------
  localparam int XPR_CYC    = `DLPCT_MAX(`DLPCT_MIN_NCK,
                                `DLPCT_CYC(TRFC_NS + `DLPCT_PAD_NS));
  localparam int XS_CYC     = `DLPCT_CYC(TRFC_NS + `DLPCT_PAD_NS);
  localparam int ABORT_CYC  = `DLPCT_CYC(REFRESH_CYCLE_TIME_4X_NS + `DLPCT_PAD_NS);
  localparam int FAST_CYC   = `DLPCT_CYC(REFRESH_CYCLE_TIME_4X_NS + `DLPCT_PAD_NS);
  localparam int CLKV_CYC   = `DLPCT_MAX(`DLPCT_MIN_NCK,
                                `DLPCT_CYC(`DLPCT_PAD_NS));
  localparam int CKE_CYC    = `DLPCT_MAX(`DLPCT_CKE_NCK, `DLPCT_CYC(`DLPCT_CKE_NS));
  localparam int CKESR_CYC  = CKE_CYC + `DLPCT_CKESR_EXTRA;
  localparam int XP_CYC     = `DLPCT_MAX(`DLPCT_XP_NCK, `DLPCT_CYC(`DLPCT_XP_NS));
  localparam int CKMPE_CYC  = MODE_UPDATE_DELAY_CYC + `DLPCT_CPDED_CYC;
  localparam int CKMPX_CYC  = CLKV_CYC;
  localparam int XMP_CYC    = XS_CYC;
  localparam int XMPDLL_CYC = XMP_CYC + LOCKED_LOOP_LOCK_TIME_CYC;
  localparam int SETUP_CYC  = `DLPCT_MAX(`DLPCT_ONE_CYC, `DLPCT_CYC(TISH_NS));
  localparam int LOWH_CYC   = `DLPCT_CYC(`DLPCT_LOW_HOLD_NS);

  // ----------------------------------------
  // Interval timers: step, fast-exit, locked loop
  // ----------------------------------------
  dlpct_tmr_if #(.W(TW)) tif [3] (.clk(sys_clk_i), .rst(reset_i));

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_tmr
      dlpct_timer #(.W(TW)) u_tmr (.bus(tif[gi]));
    end
  endgenerate

  logic          step_load;
  logic [TW-1:0] step_val;
  logic          fast_load;
  logic [TW-1:0] fast_val;
  logic          dll_load;
  logic [TW-1:0] dll_val;

  assign tif[0].load  = step_load;
  assign tif[0].value = step_val;
  assign tif[1].load  = fast_load;
  assign tif[1].value = fast_val;
  assign tif[2].load  = dll_load;
  assign tif[2].value = dll_val;

  wire step_ok = tif[0].done;
  wire fast_ok = tif[1].done;
  wire dll_ok  = tif[2].done;

  // ----------------------------------------
  // State and registered pins
  // ----------------------------------------
  dlpct_state_type state_reg;
  dlpct_state_type state_next;
  dlpct_cmd_type   cmd_reg;
  dlpct_cmd_type   cmd_next;
  logic            cs_n_reg;
  logic            cs_n_next;
  logic            cke_reg;
  logic            cke_next;
  logic            rst_n_reg;
  logic            rst_n_next;
  logic            ck_en_reg;
  logic            ck_en_next;
  logic            pd_reg;
  logic            pd_next;
  logic            init_reg;
  logic            init_next;

  // Parity latency stretches the entry windows only when parity is on
  wire [TW-1:0] pl_add = parity_en_i ? TW'(parity_latency_i) : '0;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  wire idle      = (state_reg == ST_IDLE);
  wire op_cal    = (req_op_i == OP_LONG_CAL) || (req_op_i == OP_SHORT_CAL);
  wire op_fast   = op_cal || (req_op_i == OP_MODE_TIMING);
  wire op_exit   = (req_op_i == OP_LP_EXIT) || (req_op_i == OP_MP_EXIT);
  wire idle_ok   = idle && step_ok && !op_exit
                   && (!op_fast || fast_ok)
                   && ((req_op_i != OP_CMD_DLL) || dll_ok);
  wire lp_exit_ok = (state_reg == ST_LP_IN) && (req_op_i == OP_LP_EXIT)
                    && fast_ok;
  wire mp_exit_ok = (state_reg == ST_MP_IN) && (req_op_i == OP_MP_EXIT);
  wire accept    = req_valid_i && req_ready_o;

  assign req_ready_o = idle_ok || lp_exit_ok || mp_exit_ok;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cmd_next   = CMD_DESELECT;
    cs_n_next  = 1'b1;
    cke_next   = cke_reg;
    rst_n_next = rst_n_reg;
    ck_en_next = ck_en_reg;
    pd_next    = pd_reg;
    init_next  = init_reg;
    step_load  = 1'b0;
    step_val   = '0;
    fast_load  = 1'b0;
    fast_val   = '0;
    dll_load   = 1'b0;
    dll_val    = '0;
    case (state_reg)
      ST_BOOT: begin
        step_load  = 1'b1;
        step_val   = TW'(RESET_HOLD_CYC);
        state_next = ST_RST;
      end
      ST_RST: begin
        if (step_ok) begin
          rst_n_next = 1'b1;
          ck_en_next = 1'b1;
          step_load  = 1'b1;
          step_val   = TW'(CLKV_CYC);
          state_next = ST_RST_CLK;
        end
      end
      ST_RST_CLK: begin
        if (step_ok) begin
          cke_next   = 1'b1;
          step_load  = 1'b1;
          step_val   = TW'(XPR_CYC);
          state_next = ST_XPR;
        end
      end
      ST_XPR: begin
        if (step_ok) begin
          cmd_next   = CMD_LONG_CAL;
          cs_n_next  = 1'b0;
          step_load  = 1'b1;
          step_val   = TW'(`DLPCT_INIT_CAL_CYC);
          init_next  = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (accept) begin
          cs_n_next = 1'b0;
          case (req_op_i)
            OP_LONG_CAL: begin
              cmd_next  = CMD_LONG_CAL;
              step_load = 1'b1;
              step_val  = TW'(`DLPCT_FULL_CAL_CYC);
            end
            OP_SHORT_CAL: begin
              cmd_next  = CMD_SHORT_CAL;
              step_load = 1'b1;
              step_val  = TW'(`DLPCT_SHORT_CAL_CYC);
            end
            OP_MODE_TIMING: begin
              cmd_next = CMD_MODE_WRITE;
            end
            OP_SR_ENTER, OP_PD_ENTER: begin
              // Power-down entry is a deselect with clock enable falling
              cmd_next   = (req_op_i == OP_SR_ENTER) ? CMD_SELFREF_ENTRY : CMD_DESELECT;
              cs_n_next  = (req_op_i != OP_SR_ENTER);
              pd_next    = (req_op_i == OP_PD_ENTER);
              cke_next   = 1'b0;
              step_load  = 1'b1;
              step_val   = TW'(CLKV_CYC) + pl_add;
              fast_load  = 1'b1;
              fast_val   = (req_op_i == OP_SR_ENTER) ? TW'(CKESR_CYC) + pl_add
                                                     : TW'(CKE_CYC);
              state_next = ST_LP_HOLD;
            end
            OP_MP_ENTER: begin
              // Mode write that switches the device into saving mode
              cmd_next   = CMD_MODE_WRITE;
              step_load  = 1'b1;
              step_val   = TW'(CKMPE_CYC);
              state_next = ST_MP_HOLD;
            end
            default: begin
              cmd_next = CMD_USER;
            end
          endcase
        end
      end
      ST_LP_HOLD: begin
        if (step_ok) begin
          ck_en_next = 1'b0;
          state_next = ST_LP_IN;
        end
      end
      ST_LP_IN: begin
        if (accept) begin
          ck_en_next = 1'b1;
          step_load  = 1'b1;
          step_val   = TW'(CLKV_CYC);
          state_next = ST_LP_PRECLK;
        end
      end
      ST_LP_PRECLK: begin
        if (step_ok) begin
          cke_next   = 1'b1;
          step_load  = 1'b1;
          state_next = ST_IDLE;
          if (pd_reg) begin
            step_val = TW'(XP_CYC);
          end else begin
            cmd_next  = CMD_SELFREF_EXIT;
            step_val  = abort_en_i ? TW'(ABORT_CYC) : TW'(XS_CYC);
            fast_load = 1'b1;
            fast_val  = TW'(FAST_CYC);
            dll_load  = 1'b1;
            dll_val   = TW'(LOCKED_LOOP_LOCK_TIME_CYC);
          end
          pd_next = 1'b0;
        end
      end
      ST_MP_HOLD: begin
        // Device drops its command path within this window
        if (step_ok) begin
          ck_en_next = 1'b0;
          state_next = ST_MP_IN;
        end
      end
      ST_MP_IN: begin
        if (accept) begin
          ck_en_next = 1'b1;
          step_load  = 1'b1;
          step_val   = TW'(CKMPX_CYC);
          state_next = ST_MP_PRECLK;
        end
      end
      ST_MP_PRECLK: begin
        if (step_ok) begin
          cs_n_next  = 1'b0;
          step_load  = 1'b1;
          step_val   = TW'(SETUP_CYC);
          state_next = ST_MP_SETUP;
        end
      end
      ST_MP_SETUP: begin
        cs_n_next = 1'b0;
        if (step_ok) begin
          cke_next   = 1'b1;
          step_load  = 1'b1;
          step_val   = TW'(XMP_CYC);
          fast_load  = 1'b1;
          fast_val   = TW'(LOWH_CYC);
          dll_load   = 1'b1;
          dll_val    = TW'(XMPDLL_CYC);
          state_next = ST_MP_LOWHOLD;
        end
      end
      ST_MP_LOWHOLD: begin
        // Select released once the low hold ends, far below the exit delay
        cs_n_next = fast_ok ? 1'b1 : 1'b0;
        if (fast_ok) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_BOOT;
      cmd_reg   <= CMD_DESELECT;
      cs_n_reg  <= 1'b1;
      cke_reg   <= 1'b0;
      rst_n_reg <= 1'b0;
      ck_en_reg <= 1'b0;
      pd_reg    <= 1'b0;
      init_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      cs_n_reg  <= cs_n_next;
      cke_reg   <= cke_next;
      rst_n_reg <= rst_n_next;
      ck_en_reg <= ck_en_next;
      pd_reg    <= pd_next;
      init_reg  <= init_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cmd_o          = cmd_reg;
  assign cs_n_o         = cs_n_reg;
  assign cke_o          = cke_reg;
  assign reset_n_o      = rst_n_reg;
  assign ck_en_o        = ck_en_reg;
  assign init_done_o    = init_reg;
  assign in_selfref_o   = !pd_reg && ((state_reg == ST_LP_HOLD) || (state_reg == ST_LP_IN)
                          || (state_reg == ST_LP_PRECLK));
  assign in_powerdown_o = pd_reg;
  assign in_saving_o    = (state_reg == ST_MP_HOLD) || (state_reg == ST_MP_IN)
                          || (state_reg == ST_MP_PRECLK) || (state_reg == ST_MP_SETUP);
  assign nodll_ok_o     = idle && step_ok;
  assign dll_ok_o       = idle && step_ok && dll_ok;
endmodule : dlpct_ctrl

// [verification/dlpct_dev_model.sv]
`timescale 1ns/1ps
module dlpct_dev_model
  import dlpct_pkg::*;
#(
  parameter int MODE_UPDATE_DELAY_CYC = 24,
  parameter int REFRESH_CYCLE_TIME_4X_NS = 160
) (
  input  wire logic          sys_clk_i,
  input  wire logic          reset_n_i,
  input  wire dlpct_cmd_type cmd_i,
  input  wire logic          cs_n_i,
  input  wire logic          ck_en_i,
  input  wire logic          cke_i,
  output logic               err_o
);
  localparam int XSA = (REFRESH_CYCLE_TIME_4X_NS + 19) / 10;
  // ----------------------------------------
  // Command path of the device
  // ----------------------------------------
  dlpct_cmd_type last_reg;
  logic [11:0]   age_reg;
  logic          off_reg;
  logic          ck_reg;
  wire           take  = cmd_i != CMD_DESELECT;
  wire           stop  = ck_reg && !ck_en_i;
  wire           mw    = last_reg == CMD_MODE_WRITE;
  wire           early = stop && mw && age_reg < MODE_UPDATE_DELAY_CYC + 4;
  wire           fast  = take && cmd_i == CMD_USER && last_reg == CMD_SELFREF_EXIT
                         && age_reg < XSA;
  // Commands into a stopped clock or a disabled path are lost, so flag them
  wire           deaf  = take && (off_reg || !ck_en_i);
  wire           wake  = !cs_n_i && !take;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_reg <= CMD_DESELECT;
      age_reg  <= 12'h000;
      off_reg  <= 1'b0;
      ck_reg   <= 1'b0;
      err_o    <= 1'b0;
    end else begin
      ck_reg   <= ck_en_i;
      age_reg  <= take ? 12'h001 : age_reg + {11'h000, ~&age_reg};
      last_reg <= take ? cmd_i : last_reg;
      off_reg  <= (stop && mw) || (off_reg && !wake);
      err_o    <= err_o | early | fast | deaf;
    end
  end
endmodule : dlpct_dev_model

// [verification/dlpct_ctrl_monitor.sv]
`timescale 1ns/1ps
module dlpct_ctrl_monitor
  import dlpct_pkg::*;
#(
  parameter int TRFC_NS  = 350,
  parameter int REFRESH_CYCLE_TIME_4X_NS = 160,
  parameter int MODE_UPDATE_DELAY_CYC = 24
) (
  input wire logic          sys_clk_i,
  input wire logic          reset_i,
  input wire logic          abort_en_i,
  input wire logic          parity_en_i,
  input wire logic [3:0]    parity_latency_i,
  input wire dlpct_cmd_type cmd_o,
  input wire logic          cs_n_o,
  input wire logic          cke_o,
  input wire logic          ck_en_o,
  input wire logic          init_done_o
);
  localparam int XS  = (TRFC_NS + 19) / 10;
  localparam int XSA = (REFRESH_CYCLE_TIME_4X_NS + 19) / 10;
  localparam int XPR = (XS > 5) ? XS : 5;
  // ----------------------------------------
  // Cycles since the last command and since clock enable rose
  // ----------------------------------------
  logic [11:0]   gap_reg;
  logic [11:0]   hi_reg;
  dlpct_cmd_type last_reg;
  logic          ini_reg;
  logic          init_q_reg;
  wire           issue = cmd_o != CMD_DESELECT;
  // Init flag rises with the first calibration, so look at its previous value
  wire           first_cal = (cmd_o == CMD_LONG_CAL) && !init_q_reg;
  wire  [4:0]    pl    = parity_en_i ? {1'b0, parity_latency_i} : 5'h00;
  wire           self_refresh_entry   = last_reg == CMD_SELFREF_ENTRY;
  wire           self_refresh_exit   = last_reg == CMD_SELFREF_EXIT;
  wire           lcal  = last_reg == CMD_LONG_CAL;
  wire           cal   = cmd_o inside {CMD_LONG_CAL, CMD_SHORT_CAL, CMD_MODE_WRITE};
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_reg  <= 12'h000;
      hi_reg   <= 12'h000;
      last_reg <= CMD_DESELECT;
      ini_reg  <= 1'b0;
      init_q_reg <= 1'b0;
    end else begin
      init_q_reg <= init_done_o;
      gap_reg  <= issue ? 12'h001 : gap_reg + {11'h000, ~&gap_reg};
      hi_reg   <= cke_o ? hi_reg + {11'h000, ~&hi_reg} : 12'h000;
      last_reg <= issue ? cmd_o : last_reg;
      ini_reg  <= issue ? first_cal : ini_reg;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  AST_INIT_CAL: assert property (issue && ini_reg |-> gap_reg >= 1024)
    else $error("command too soon after initial calibration");
  AST_LONG_CAL: assert property (issue && lcal && !ini_reg |-> gap_reg >= 512)
    else $error("command too soon after long calibration");
  AST_SHORT_CAL: assert property (issue && last_reg == CMD_SHORT_CAL |-> gap_reg >= 128)
    else $error("command too soon after short calibration");
  AST_RESET_EXIT: assert property (first_cal |-> hi_reg >= XPR)
    else $error("first command too soon after clock enable");
  AST_SR_EXIT: assert property (cmd_o == CMD_USER && self_refresh_exit |-> gap_reg >= (abort_en_i ? XSA : XS))
    else $error("command too soon after self refresh exit");
  AST_FAST_EXIT: assert property (cal && self_refresh_exit |-> gap_reg >= XSA)
    else $error("calibration or timing write too soon after exit");
  AST_CKE_LOW: assert property ($rose(cke_o) && self_refresh_entry |-> gap_reg >= 4 + pl)
    else $error("clock enable low width too short");
  AST_CLK_AFTER_SR: assert property ($fell(ck_en_o) && self_refresh_entry |-> gap_reg >= 5 + pl)
    else $error("clock stopped too soon after self refresh entry");
  AST_CLK_AFTER_MP: assert property ($fell(ck_en_o) && last_reg == CMD_MODE_WRITE |-> gap_reg >= MODE_UPDATE_DELAY_CYC + 4)
    else $error("clock stopped too soon after saving mode entry");
  AST_CLK_BEFORE_EXIT: assert property ($rose(cke_o) |-> $past(ck_en_o, 5))
    else $error("clock not valid long enough before exit");
  AST_SEL_EXIT: assert property ($rose(cke_o) && !cs_n_o |-> !$past(cs_n_o) ##1 !cs_n_o ##[1:4] cs_n_o)
    else $error("select timing wrong on saving mode exit");
  COV_SR: cover property (cmd_o == CMD_SELFREF_EXIT);
  COV_MP: cover property ($rose(cke_o) && !cs_n_o);
  COV_ZQ: cover property (cmd_o == CMD_SHORT_CAL);
endmodule : dlpct_ctrl_monitor

bind dlpct_ctrl dlpct_ctrl_monitor #(
  .TRFC_NS(TRFC_NS), .REFRESH_CYCLE_TIME_4X_NS(REFRESH_CYCLE_TIME_4X_NS), .MODE_UPDATE_DELAY_CYC(MODE_UPDATE_DELAY_CYC)
) mon_u (
  .sys_clk_i, .reset_i, .abort_en_i, .parity_en_i, .parity_latency_i, .cmd_o, .cs_n_o,
  .cke_o, .ck_en_o, .init_done_o
);

// [verification/dlpct_ctrl_bench.sv]
`timescale 1ns/1ps
module dlpct_ctrl_bench;
  import dlpct_pkg::*;
  // ----------------------------------------
  // Short refresh and lock figures keep the run brief
  // ----------------------------------------
  localparam int XS  = 6;
  localparam int XSA = 4;
  logic          sys_clk_i        = 1'b0;
  logic          reset_i          = 1'b1;
  logic          req_valid_i      = 1'b0;
  dlpct_op_type  req_op_i         = OP_CMD_NODLL;
  logic          abort_en_i       = 1'b0;
  logic          parity_en_i      = 1'b0;
  logic [3:0]    parity_latency_i = 4'h0;
  logic          req_ready_o, cs_n_o, cke_o, reset_n_o, ck_en_o, init_done_o, dev_err;
  logic          in_selfref_o, in_powerdown_o, in_saving_o, nodll_ok_o, dll_ok_o;
  dlpct_cmd_type cmd_o;
  int            error_cnt   = 0;
  int            comparisons = 0;
  dlpct_ctrl #(.TRFC_NS(50), .REFRESH_CYCLE_TIME_4X_NS(30), .LOCKED_LOOP_LOCK_TIME_CYC(20)) dut_u (
    .sys_clk_i, .reset_i, .req_valid_i, .req_op_i, .req_ready_o, .abort_en_i, .parity_en_i,
    .parity_latency_i, .cmd_o, .cs_n_o, .cke_o, .reset_n_o, .ck_en_o, .init_done_o,
    .in_selfref_o, .in_powerdown_o, .in_saving_o, .nodll_ok_o, .dll_ok_o
  );
  dlpct_dev_model #(.REFRESH_CYCLE_TIME_4X_NS(30)) dev_u (
    .sys_clk_i, .reset_n_i(reset_n_o), .cmd_i(cmd_o), .cs_n_i(cs_n_o), .ck_en_i(ck_en_o),
    .cke_i(cke_o), .err_o(dev_err)
  );
  always #5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until taken; a refused request waits, and is dropped and counted as a failure after 3000 cycles
  task automatic do_op(input dlpct_op_type op, output int n);
    @(negedge sys_clk_i);
    req_valid_i = 1'b1;
    req_op_i    = op;
    n = 0;
    // Let ready settle on the new operation before it is read
    #1;
    while (!req_ready_o && n < 3000) begin
      @(negedge sys_clk_i);
      n++;
    end
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    chk(16'(n < 3000), 16'h0001);
  endtask : do_op
  task automatic t_boot;
    int n;
    n = 0;
    while (!init_done_o && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(reset_n_o & ck_en_o & cke_o & init_done_o, 16'h0001);
    do_op(OP_CMD_NODLL, n);
    chk(16'(n >= 1018 && n <= 1024), 16'h0001);
    $display("boot test done");
  endtask : t_boot
  task automatic t_cal;
    dlpct_op_type  ops[2]  = '{OP_LONG_CAL, OP_SHORT_CAL};
    dlpct_cmd_type cmds[2] = '{CMD_LONG_CAL, CMD_SHORT_CAL};
    int            len[2]  = '{512, 128};
    int            n;
    for (int i = 0; i < 2; i++) begin
      do_op(ops[i], n);
      chk(cmd_o, cmds[i]);
      do_op(OP_CMD_NODLL, n);
      chk(16'(n >= len[i] - 3 && n <= len[i]), 16'h0001);
    end
    do_op(OP_CMD_DLL, n);
    do_op(OP_MODE_TIMING, n);
    chk(16'(n), 16'h0000);
    $display("calibration test done");
  endtask : t_cal
  task automatic t_lp(input dlpct_op_type op, input logic ab, input int x,
                      input dlpct_op_type nxt);
    int n;
    abort_en_i = ab;
    do_op(op, n);
    chk(cs_n_o, op == OP_PD_ENTER);
    chk({in_selfref_o, in_powerdown_o, cke_o}, {op == OP_SR_ENTER, op == OP_PD_ENTER, 1'b0});
    do_op(OP_LP_EXIT, n);
    do_op(nxt, n);
    chk(16'(n >= x + 1 && n <= x + 6), 16'h0001);
    chk({in_selfref_o, in_powerdown_o, cke_o}, 16'h0001);
    chk({nodll_ok_o, dll_ok_o}, {1'b1, op == OP_PD_ENTER});
    do_op(OP_CMD_DLL, n);
    $display("low power test done");
  endtask : t_lp
  task automatic t_mp;
    int n;
    do_op(OP_MP_ENTER, n);
    chk(cmd_o, CMD_MODE_WRITE);
    n = 0;
    while (ck_en_o && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(16'(n >= 26 && n <= 30 && in_saving_o), 16'h0001);
    do_op(OP_MP_EXIT, n);
    do_op(OP_CMD_DLL, n);
    chk(16'(n >= XS + 20 && !in_saving_o), 16'h0001);
    $display("saving mode test done");
  endtask : t_mp
  task automatic t_rst;
    chk(dev_err, 1'b0);
    @(negedge sys_clk_i);
    reset_i          = 1'b1;
    parity_en_i      = 1'b1;
    parity_latency_i = 4'h2;
    repeat (4) @(negedge sys_clk_i);
    chk({reset_n_o, cke_o, ck_en_o, cs_n_o, req_ready_o, cmd_o}, {5'h02, CMD_DESELECT});
    reset_i = 1'b0;
    $display("reset test done");
    t_boot();
  endtask : t_rst
  task automatic final_report;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(negedge sys_clk_i);
    reset_i = 1'b0;
    t_boot();
    t_cal();
    t_lp(OP_SR_ENTER, 1'b0, XS, OP_CMD_NODLL);
    t_lp(OP_SR_ENTER, 1'b1, XSA, OP_CMD_NODLL);
    t_lp(OP_PD_ENTER, 1'b0, 4, OP_CMD_NODLL);
    t_mp();
    t_rst();
    t_lp(OP_SR_ENTER, 1'b0, XS, OP_MODE_TIMING);
    chk(dev_err, 1'b0);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    final_report();
  end
endmodule : dlpct_ctrl_bench
